// ===== acr_defines.svh
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

// register port map (indices on the 3-bit address port)
`define ACR_ADDR_SELECT 3'h0
`define ACR_ADDR_CTRL 3'h1
`define ACR_ADDR_RES_LO 3'h2
`define ACR_ADDR_RES_HI 3'h3

// input_select_reg fields
`define ACR_SEL_REF_HI 7
`define ACR_SEL_REF_LO 6
`define ACR_SEL_LEFT 5
`define ACR_SEL_MUX_HI 4
`define ACR_SEL_RESET 8'h00

// control register fields
`define ACR_CTL_EN 7
`define ACR_CTL_START 6
`define ACR_CTL_FREE 5
`define ACR_CTL_DONE 4
`define ACR_CTL_IE 3

// reference select encodings
`define ACR_REF_EXT 2'h0
`define ACR_REF_SUPPLY 2'h1
`define ACR_REF_RSVD 2'h2
`define ACR_REF_INT 2'h3

// differential channel range of the input select field
`define ACR_MUX_DIFF_LO 5'h08
`define ACR_MUX_DIFF_HI 5'h1d

// converter clock is mclk divided by (ACR_DIV_LAST + 1)
`define ACR_DIV_LAST 4'h7
// conversion lengths in converter clocks
`define ACR_LEN_FIRST 5'h19
`define ACR_LEN_NORMAL 5'h0d
// successive approximation occupies the ten ticks before the last one
`define ACR_SAR_LEAD 5'h0b
`define ACR_SAR_TAIL 5'h02

// successive approximation register
`define ACR_CODE_MID 10'h200
`define ACR_CODE_ZERO 10'h000
`define ACR_SAR_MSB 4'h9

`endif

// ===== acr_pkg.sv
package acr_pkg;

    typedef enum logic [2:0] {
        ACR_SLP_NONE = 3'h0,
        ACR_SLP_IDLE = 3'h1,
        ACR_SLP_NOISE = 3'h2,
        ACR_SLP_PWR_DOWN = 3'h3,
        ACR_SLP_PWR_SAVE = 3'h4,
        ACR_SLP_STANDBY = 3'h5,
        ACR_SLP_EXT_STANDBY = 3'h6
    } acr_sleep_t;

    typedef enum logic [1:0] {
        ACR_IDLE = 2'b00,
        ACR_CONV = 2'b01
    } acr_state_t;

    typedef struct packed {
        logic [9:0] code;
        logic [3:0] idx;
    } acr_sar_regs_t;

    typedef struct packed {
        acr_state_t state;
        logic [7:0] sel;
        logic [1:0] act_ref;
        logic [4:0] act_mux;
        logic enable;
        logic busy;
        logic free_run;
        logic done;
        logic irq_en;
        logic first;
        logic [3:0] div;
        logic [4:0] tick;
        logic [9:0] result;
        logic sar_clear;
        logic sar_step;
        logic halted_q;
        logic [1:0] cmp_sync;
        logic [7:0] rdata;
    } acr_regs_t;

endpackage : acr_pkg

// ===== acr_sar.sv
`timescale 1ns/1ns
`include "acr_defines.svh"

module acr_sar (
    input wire logic mclk,
    input wire logic srst_n,
    input wire logic clear,
    input wire logic step,
    input wire logic cmp_hi,
    output logic [9:0] code
);

    acr_pkg::acr_sar_regs_t r;
    acr_pkg::acr_sar_regs_t next_r;

    // binary search: keep the trial bit while the input is at or above the trial level
    always_comb begin
        next_r = r;
        if (clear) begin
            next_r.code = `ACR_CODE_MID;
            next_r.idx = `ACR_SAR_MSB;
        end else if (step) begin
            if (!cmp_hi) begin
                next_r.code[r.idx] = 1'b0;
            end
            if (r.idx != 4'h0) begin
                next_r.code[4'(r.idx - 4'h1)] = 1'b1;
                next_r.idx = 4'(r.idx - 4'h1);
            end
        end
    end

    always_ff @(posedge mclk or negedge srst_n) begin
        if (!srst_n) begin
            r <= '{code: `ACR_CODE_ZERO, idx: 4'h0};
        end else begin
            r <= next_r;
        end
    end

    // an input above the reference keeps every bit, saturating at the top code
    assign code = r.code;

endmodule : acr_sar

// ===== acr_top.sv
`timescale 1ns/1ns
`include "acr_defines.svh"

// How it works
// - free-run restart takes up the latest channel selection
// - idle or noise-reduction sleep halt starts conversion automatically
// - completion raises request; it wakes CPU
// - other sleep modes never clear enable
// - result held in result registers once done
// - single-ended result is unsigned ten-bit code
// - differential result is two's-complement ten-bit code
// - top result bit is the sign of a differential result
// - three reference sources selectable
// - reference field encodes external, supply, reserved, internal
// - left-align bit reformats result at once
// - selection changes wait for running conversion to finish
module acr_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire acr_pkg::acr_sleep_t sleep_mode,
    input wire logic cpu_halted,
    input wire logic cmp_in,
    output logic ana_enable,
    output logic [4:0] ana_channel,
    output logic [1:0] ana_reference,
    output logic [9:0] dac_code,
    output logic busy,
    output logic irq_request,
    output logic wake_request
);

    logic [1:0] rst_sync;
    logic srst_n;

    acr_pkg::acr_regs_t r;
    acr_pkg::acr_regs_t next_r;

    logic [9:0] sar_code;
    logic cmp_hi;
    logic conv_tick;
    logic [4:0] conv_len;
    logic last_tick;
    logic in_sar_window;
    logic act_is_diff;
    logic sleep_start;
    logic wr_ctrl;
    logic [9:0] coded_result;
    logic [7:0] res_lo;
    logic [7:0] res_hi;

    // reset asserts at once, releases two edges later
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign srst_n = rst_sync[1];

    acr_sar i_acr_sar (
        .mclk(mclk),
        .srst_n(srst_n),
        .clear(r.sar_clear),
        .step(r.sar_step),
        .cmp_hi(cmp_hi),
        .code(sar_code)
    );

    // comparator comes from the analog side, so only the second stage is used
    assign cmp_hi = r.cmp_sync[1];

    assign conv_tick = r.enable && (r.div == `ACR_DIV_LAST);
    assign conv_len = r.first ? `ACR_LEN_FIRST : `ACR_LEN_NORMAL;
    assign last_tick = (r.tick == 5'(conv_len - 5'h01));
    assign in_sar_window = (r.tick >= 5'(conv_len - `ACR_SAR_LEAD))
        && (r.tick <= 5'(conv_len - `ACR_SAR_TAIL));

    assign act_is_diff = (r.act_mux >= `ACR_MUX_DIFF_LO) && (r.act_mux <= `ACR_MUX_DIFF_HI);

    // offset-binary search becomes two's complement by flipping the top bit
    assign coded_result = act_is_diff ? {~sar_code[9], sar_code[8:0]} : sar_code;

    // the CPU must have armed enable, single mode and the interrupt beforehand
    assign sleep_start = cpu_halted && !r.halted_q && r.enable && !r.busy && !r.free_run
        && r.irq_en
        && ((sleep_mode == acr_pkg::ACR_SLP_IDLE)
        || (sleep_mode == acr_pkg::ACR_SLP_NOISE));

    assign wr_ctrl = wr && (addr == `ACR_ADDR_CTRL);

    // alignment uses the live bit, so it changes a held result without a new conversion
    always_comb begin
        if (r.sel[`ACR_SEL_LEFT]) begin
            res_lo = {r.result[1:0], 6'h00};
            res_hi = r.result[9:2];
        end else begin
            res_lo = r.result[7:0];
            res_hi = {6'h00, r.result[9:8]};
        end
    end

    always_comb begin
        next_r = r;
        next_r.cmp_sync = {r.cmp_sync[0], cmp_in};
        next_r.halted_q = cpu_halted;
        next_r.sar_clear = 1'b0;
        next_r.sar_step = 1'b0;

        // converter clock prescaler only runs while enabled
        if (!r.enable || (r.div == `ACR_DIV_LAST)) begin
            next_r.div = 4'h0;
        end else begin
            next_r.div = 4'(r.div + 4'h1);
        end

        // software side of the selection is always writable
        if (wr && (addr == `ACR_ADDR_SELECT)) begin
            next_r.sel = wdata;
        end

        if (wr_ctrl) begin
            next_r.enable = wdata[`ACR_CTL_EN];
            next_r.free_run = wdata[`ACR_CTL_FREE];
            next_r.irq_en = wdata[`ACR_CTL_IE];
            if (!r.enable && wdata[`ACR_CTL_EN]) begin
                next_r.first = 1'b1;
            end
            // writing zero to the start bit is ignored; start needs enable in the same write
            if (wdata[`ACR_CTL_START] && wdata[`ACR_CTL_EN]) begin
                next_r.busy = 1'b1;
            end
            if (wdata[`ACR_CTL_DONE]) begin
                next_r.done = 1'b0;
            end
        end

        // sleep modes never touch enable; only idle and noise reduction start work
        if (sleep_start) begin
            next_r.busy = 1'b1;
        end

        unique case (r.state)
            acr_pkg::ACR_IDLE: begin
                // selection tracks software freely until a conversion begins
                next_r.act_ref = r.sel[`ACR_SEL_REF_HI:`ACR_SEL_REF_LO];
                next_r.act_mux = r.sel[`ACR_SEL_MUX_HI:0];
                // a start written now begins on the next converter clock, then locks
                if (r.busy && conv_tick) begin
                    next_r.state = acr_pkg::ACR_CONV;
                    next_r.tick = 5'h00;
                    next_r.sar_clear = 1'b1;
                end
            end
            acr_pkg::ACR_CONV: begin
                if (conv_tick) begin
                    next_r.tick = 5'(r.tick + 5'h01);
                    if (in_sar_window) begin
                        next_r.sar_step = 1'b1;
                    end
                    if (last_tick) begin
                        // result only moves here; it stands until the next completion
                        next_r.result = coded_result;
                        next_r.done = 1'b1;
                        next_r.first = 1'b0;
                        // pending selection takes effect only now
                        next_r.act_ref = r.sel[`ACR_SEL_REF_HI:`ACR_SEL_REF_LO];
                        next_r.act_mux = r.sel[`ACR_SEL_MUX_HI:0];
                        if (r.free_run) begin
                            // restart at once; a later write lands mid-conversion and waits
                            next_r.tick = 5'h00;
                            next_r.sar_clear = 1'b1;
                        end else begin
                            next_r.busy = 1'b0;
                            next_r.state = acr_pkg::ACR_IDLE;
                        end
                    end
                end
            end
        endcase

        // disable aborts a conversion and arms the extended first one
        if (wr_ctrl && !wdata[`ACR_CTL_EN]) begin
            next_r.state = acr_pkg::ACR_IDLE;
            next_r.busy = 1'b0;
            next_r.first = 1'b1;
        end

        // read data stand only in the cycle after the strobe
        next_r.rdata = 8'h00;
        if (rd) begin
            unique case (addr)
                `ACR_ADDR_SELECT: next_r.rdata = r.sel;
                `ACR_ADDR_CTRL: next_r.rdata = {r.enable, r.busy, r.free_run, r.done,
                    r.irq_en, 3'h0};
                `ACR_ADDR_RES_LO: next_r.rdata = res_lo;
                `ACR_ADDR_RES_HI: next_r.rdata = res_hi;
                default: next_r.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge srst_n) begin
        if (!srst_n) begin
            r <= '{
                state: acr_pkg::ACR_IDLE,
                sel: `ACR_SEL_RESET,
                act_ref: `ACR_REF_EXT,
                act_mux: 5'h00,
                enable: 1'b0,
                busy: 1'b0,
                free_run: 1'b0,
                done: 1'b0,
                irq_en: 1'b0,
                first: 1'b1,
                div: 4'h0,
                tick: 5'h00,
                result: `ACR_CODE_ZERO,
                sar_clear: 1'b0,
                sar_step: 1'b0,
                halted_q: 1'b0,
                cmp_sync: 2'h0,
                rdata: 8'h00
            };
        end else begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign ana_enable = r.enable;
    assign ana_channel = r.act_mux;
    assign ana_reference = r.act_ref;
    assign dac_code = sar_code;
    assign busy = r.busy;
    // request stays pending even if the CPU woke for something else
    assign irq_request = r.done && r.irq_en;
    assign wake_request = irq_request;

endmodule : acr_top

// ===== acr_analog_model.sv
`timescale 1ns/1ns
module acr_analog_model (
    input logic mclk,
    input logic ana_enable,
    input logic [4:0] ana_channel,
    input logic [1:0] ana_reference,
    input logic [9:0] dac_code,
    output logic cmp_in
);
    logic [9:0] level;
    // level encodes channel and reference, so each result shows which pair was sampled
    // no fixed voltage sits on the external reference pin, so internal choices are safe
    assign level = {ana_channel, ana_reference, 3'h5};
    // inputs are ideal and no port pin toggles as a digital output meanwhile
    initial cmp_in = 1'b0;
    always @(posedge mclk) begin
        // switched off: the comparator output is meaningless, so it wanders
        cmp_in <= ana_enable ? (level >= dac_code) : !cmp_in;
    end
endmodule : acr_analog_model

// ===== acr_top_asserts.sv
`timescale 1ns/1ns
`include "acr_defines.svh"
module acr_checker (
    input logic mclk,
    input logic rst_n,
    input logic [2:0] addr,
    input logic [7:0] wdata,
    input logic wr,
    input logic rd,
    input logic [7:0] rdata,
    input acr_pkg::acr_sleep_t sleep_mode,
    input logic cpu_halted,
    input logic ana_enable,
    input logic [4:0] ana_channel,
    input logic [1:0] ana_reference,
    input logic [9:0] dac_code,
    input logic busy,
    input logic irq_request,
    input logic wake_request
);
    logic [8:0] busy_cnt;
    // saturates so a long free-running stretch never wraps
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            busy_cnt <= 9'h000;
        else if (!busy)
            busy_cnt <= 9'h000;
        else if (busy_cnt != 9'h1ff)
            busy_cnt <= busy_cnt + 9'h001;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_wake; wake_request == irq_request; endproperty
    property p_rd_idle; !rd |=> rdata == 8'h00; endproperty
    property p_lock;
        $changed(dac_code) && dac_code != `ACR_CODE_MID
            |-> $stable(ana_channel) && $stable(ana_reference);
    endproperty
    property p_en_hold; ana_enable && !(wr && addr == `ACR_ADDR_CTRL) |=> ana_enable; endproperty
    property p_en_off; !ana_enable |-> !busy; endproperty
    property p_start;
        wr && addr == `ACR_ADDR_CTRL && wdata[`ACR_CTL_EN] && wdata[`ACR_CTL_START] |=> busy;
    endproperty
    property p_rise;
        $rose(busy) |-> ($past(wr) && $past(addr) == `ACR_ADDR_CTRL) || ($past(cpu_halted)
            && $past(sleep_mode) inside {acr_pkg::ACR_SLP_IDLE, acr_pkg::ACR_SLP_NOISE});
    endproperty
    property p_len; $fell(busy) && ana_enable |-> busy_cnt >= 9'h050; endproperty
    a_wake: assert property (p_wake) else $error("wake differs from irq");
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");
    a_lock: assert property (p_lock) else $error("selection moved mid-conversion");
    a_en_hold: assert property (p_en_hold) else $error("enable dropped");
    a_en_off: assert property (p_en_off) else $error("busy while disabled");
    a_start: assert property (p_start) else $error("start ignored");
    a_rise: assert property (p_rise) else $error("busy rose without cause");
    a_len: assert property (p_len) else $error("conversion too short");
    c_sleep: cover property ($rose(cpu_halted) ##[1:3] $rose(busy));
    c_irq: cover property ($rose(irq_request));
    c_done: cover property ($fell(busy) && ana_enable);
endmodule : acr_checker
bind acr_top acr_checker i_acr_checker (.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .sleep_mode, .cpu_halted, .ana_enable, .ana_channel, .ana_reference, .dac_code, .busy,
    .irq_request, .wake_request);

// ===== acr_top_bench.sv
`timescale 1ns/1ns
`include "acr_defines.svh"
module acr_top_bench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    acr_pkg::acr_sleep_t sleep_mode = acr_pkg::ACR_SLP_NONE;
    logic cpu_halted = 1'b0;
    logic [7:0] rdata;
    logic cmp_in, ana_enable, busy, irq_request, wake_request;
    logic [4:0] ana_channel;
    logic [1:0] ana_reference;
    logic [9:0] dac_code;
    logic [7:0] d;
    logic [7:0] s;
    logic [4:0] chans [4] = '{5'h03, 5'h08, 5'h10, 5'h1f};
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    initial forever #5 mclk = ~mclk;
    acr_top i_acr_top (.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .sleep_mode,
        .cpu_halted, .cmp_in, .ana_enable, .ana_channel, .ana_reference, .dac_code, .busy,
        .irq_request, .wake_request);
    acr_analog_model i_acr_analog_model (.mclk, .ana_enable, .ana_channel, .ana_reference,
        .dac_code, .cmp_in);
    task tally_and_finish;
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    task chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    task wait_for(input logic want_irq);
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge mclk);
            #1;
            if (want_irq ? irq_request === 1'b1 : busy === 1'b0) break;
        end
        chk("wait", 10'h000, {9'h000, i == 400});
    endtask : wait_for
    // differential channels come out offset binary with the top bit flipped
    function logic [9:0] expect_code(input logic [4:0] ch, input logic [1:0] rf);
        expect_code = {ch, rf, 3'h5};
        if (ch >= `ACR_MUX_DIFF_LO && ch <= `ACR_MUX_DIFF_HI)
            expect_code[9] = ~expect_code[9];
    endfunction : expect_code
    task chk_res(input logic [7:0] sv, input logic [9:0] x);
        rd_reg(`ACR_ADDR_RES_LO, d);
        chk("res_lo", {2'h0, x[7:0]}, {2'h0, d});
        rd_reg(`ACR_ADDR_RES_HI, d);
        chk("res_hi", {8'h00, x[9:8]}, {2'h0, d});
        wr_reg(`ACR_ADDR_SELECT, sv | 8'h20);
        rd_reg(`ACR_ADDR_RES_LO, d);
        chk("left_lo", {2'h0, x[1:0], 6'h00}, {2'h0, d});
        rd_reg(`ACR_ADDR_RES_HI, d);
        chk("left_hi", {2'h0, x[9:2]}, {2'h0, d});
        wr_reg(`ACR_ADDR_SELECT, sv);
    endtask : chk_res
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd_reg(`ACR_ADDR_CTRL, d);
        chk("ctrl_rst", 10'h000, {2'h0, d});
        rd_reg(`ACR_ADDR_SELECT, d);
        chk("sel_rst", {2'h0, `ACR_SEL_RESET}, {2'h0, d});
        rd_reg(3'h5, d);
        chk("unmapped", 10'h000, {2'h0, d});
        // the model settles at once, so first results after a switch are kept
        for (int k = 0; k < 4; k++) begin
            s = {k[1:0], 1'b0, chans[k]};
            wr_reg(`ACR_ADDR_SELECT, s);
            wr_reg(`ACR_ADDR_CTRL, 8'hc8);
            repeat (8) @(posedge mclk);
            wr_reg(`ACR_ADDR_SELECT, ~s & 8'hdf);
            wait_for(1'b0);
            chk("irq", 10'h001, {9'h000, irq_request});
            chk("act_chan", {5'h00, ~chans[k]}, {5'h00, ana_channel});
            chk("act_ref", {8'h00, ~k[1:0]}, {8'h00, ana_reference});
            chk_res(s, expect_code(chans[k], k[1:0]));
            wr_reg(`ACR_ADDR_CTRL, 8'h98);
        end
        // selection written after the first free-running result lands one result later
        wr_reg(`ACR_ADDR_SELECT, 8'h42);
        wr_reg(`ACR_ADDR_CTRL, 8'he8);
        wait_for(1'b1);
        wr_reg(`ACR_ADDR_SELECT, 8'h45);
        wr_reg(`ACR_ADDR_CTRL, 8'hb8);
        wait_for(1'b1);
        chk_res(8'h45, expect_code(5'h02, 2'h1));
        wr_reg(`ACR_ADDR_CTRL, 8'hb8);
        wait_for(1'b1);
        chk_res(8'h45, expect_code(5'h05, 2'h1));
        wr_reg(`ACR_ADDR_CTRL, 8'h98);
        wait_for(1'b0);
        wr_reg(`ACR_ADDR_CTRL, 8'h98);
        sleep_mode <= acr_pkg::ACR_SLP_PWR_DOWN;
        cpu_halted <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        chk("busy_pd", 10'h000, {9'h000, busy});
        chk("en_pd", 10'h001, {9'h000, ana_enable});
        @(posedge mclk);
        cpu_halted <= 1'b0;
        sleep_mode <= acr_pkg::ACR_SLP_NOISE;
        @(posedge mclk);
        cpu_halted <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        chk("busy_sleep", 10'h001, {9'h000, busy});
        wait_for(1'b1);
        chk("wake", 10'h001, {9'h000, wake_request});
        cpu_halted <= 1'b0;
        // idle sleep starts a conversion as well
        wr_reg(`ACR_ADDR_CTRL, 8'h98);
        sleep_mode <= acr_pkg::ACR_SLP_IDLE;
        cpu_halted <= 1'b1;
        wait_for(1'b1);
        chk("wake_idle", 10'h001, {9'h000, wake_request});
        cpu_halted <= 1'b0;
        sleep_mode <= acr_pkg::ACR_SLP_NONE;
        tally_and_finish;
    end
endmodule : acr_top_bench
